// File: testbench/efd_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module efd_drive_model #(
  parameter logic [15:0] ID   = 16'h1234,
  parameter bit          PROT = 1'b0,
  parameter bit          DISK = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic sel_n_i,
  input  wire logic motor_n_i,
  input  wire logic step_n_i,
  input  wire logic dir_i,
  output logic      ready_n_o,
  output logic      track_zero_n_o,
  output logic      write_protect_n_o,
  output logic      index_n_o,
  output logic      disk_changed_n_o,
  output logic      read_data_n_o
);
  logic       motor   = 1'b0;
  logic       changed = 1'b1;
  logic [3:0] bit_idx = 4'hf;
  logic [6:0] track   = 7'h00;
  logic [4:0] rev     = 5'h00;
  wire        sel     = !sel_n_i;
  // Turning the motor off rewinds the identifier shifter
  always @(negedge sel_n_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      motor <= 1'b0;
    end else begin
      bit_idx <= (motor && motor_n_i) ? 4'hf : bit_idx + 4'h1;
      motor   <= !motor_n_i;
    end
  end
  always @(negedge step_n_i) begin
    if (sel) begin
      if (!dir_i) track <= track + 7'h01;
      else if (track != 7'h00) track <= track - 7'h01;
      if (DISK) changed <= 1'b0;
    end
  end
  always @(posedge clk_i) rev <= rev + 5'h01;
  // Unselected: lines left to their pull-ups
  assign ready_n_o = !sel || (motor ? !DISK : ID[4'hf - bit_idx]);
  assign track_zero_n_o = !(sel && track == 7'h00);
  assign write_protect_n_o = !(sel && (PROT || !reset_n_i));
  // Pulse spans several clocks so the host filter passes it
  assign index_n_o = !(sel && motor && DISK && rev[4:2] == 3'h0);
  assign disk_changed_n_o = !(sel && (changed || !DISK));
  assign read_data_n_o = !(sel && motor && rev[1]);
endmodule : efd_drive_model
`default_nettype wire

// File: testbench/efd_host_sva.sv
`timescale 1ns/1ps
`default_nettype none
module efd_host_sva #(
  parameter int STEP_WIDTH_CYC = 10
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic side_one_i,
  input wire logic write_enable_i,
  input wire logic motor_on_n_o,
  input wire logic drive1_select_n_o,
  input wire logic drive2_select_n_o,
  input wire logic drive3_select_n_o,
  input wire logic drive_reset_n_o,
  input wire logic head_side_n_o,
  input wire logic write_gate_n_o,
  input wire logic head_step_n_o,
  input wire logic step_direction_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire  [2:0] sel_n = {drive3_select_n_o, drive2_select_n_o, drive1_select_n_o};
  logic [7:0] motor_age;
  logic [7:0] sel_age;
  logic [7:0] step_low;
  sequence s_sel_edge;
    |($past(sel_n) & ~sel_n);
  endsequence
  sequence s_pwr_hold;
    !drive_reset_n_o [*8];
  endsequence
  // Ages saturate so a long idle spell never wraps to a small value
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) motor_age <= 8'hff;
    else if ($changed(motor_on_n_o)) motor_age <= 8'h01;
    else if (motor_age != 8'hff) motor_age <= motor_age + 8'h01;
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) sel_age <= 8'hff;
    else if (|($past(sel_n) & ~sel_n)) sel_age <= 8'h01;
    else if (sel_age != 8'hff) sel_age <= sel_age + 8'h01;
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || head_step_n_o) step_low <= 8'h00;
    else step_low <= step_low + 8'h01;
  end
  a_motor_setup: assert property (s_sel_edge |-> motor_age >= 8'd14)
    else $error("motor line moved too close before select");
  a_motor_hold: assert property ($changed(motor_on_n_o) |-> sel_age >= 8'd14)
    else $error("motor line moved too soon after select");
  a_power_reset: assert property ($rose(reset_n_i) |-> s_pwr_hold)
    else $error("drive reset released early");
  a_one_select: assert property ($countones(sel_n) >= 2)
    else $error("two drives selected");
  a_side_follow: assert property (side_one_i |=> !head_side_n_o)
    else $error("head side not driven");
  a_gate_follow: assert property (write_enable_i |=> !write_gate_n_o)
    else $error("write gate not driven");
  a_dir_steady: assert property ($fell(head_step_n_o) |-> $stable(step_direction_o))
    else $error("direction moved with step");
  a_step_width: assert property ($rose(head_step_n_o) |-> step_low == 8'(STEP_WIDTH_CYC))
    else $error("step pulse width wrong");
endmodule : efd_host_sva
bind efd_host efd_host_sva #(.STEP_WIDTH_CYC(STEP_WIDTH_CYC)) efd_host_sva_inst (.clk_i,
  .reset_n_i, .side_one_i, .write_enable_i, .motor_on_n_o, .drive1_select_n_o,
  .drive2_select_n_o, .drive3_select_n_o, .drive_reset_n_o, .head_side_n_o,
  .write_gate_n_o, .head_step_n_o, .step_direction_o);
`default_nettype wire

// File: testbench/efd_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module efd_host_tb
  import efd_pkg::*;
;
  logic clk_i, reset_n_i, motor_req_i, motor_on_i, step_req_i, step_out_i, id_req_i;
  logic select_req_i, side_one_i, write_enable_i, write_bit_i, cpu_reset_i, kbd_reset_i;
  logic busy_o, done_o, track_zero_o, write_protect_o, index_o, disk_changed_o, ready_o;
  logic read_bit_o, motor_on_n_o, drive1_select_n_o, drive2_select_n_o, drive3_select_n_o;
  logic drive_reset_n_o, head_side_n_o, write_gate_n_o, write_data_n_o, head_step_n_o;
  logic step_direction_o, read_data_n_i, disk_changed_n_i, write_protect_n_i;
  logic track_zero_n_i, index_n_i, ready_n_i;
  logic [1:0]  drive_i;
  logic [15:0] drive_id_o;
  efd_type_t   drive_type_o;
  logic [2:0]  sel_n, rdy_n, tz_n, wp_n, ix_n, ch_n, rd_n;
  int          fail_count = 0;
  int          comparisons = 0;
  // Arbitrary identifier values
  localparam logic [15:0] IDS [3] = '{16'h1234, 16'h3333, 16'h7000};
  localparam efd_type_t TYPES [3] = '{EFD_TYPE_UNKNOWN, EFD_TYPE_RESERVED, EFD_TYPE_RESERVED};

  efd_host #(.STEP_WIDTH_CYC(4), .STEP_GAP_CYC(20), .RESET_PWR_CYC(50)) efd_host_inst (
    .clk_i, .reset_n_i, .drive_i, .motor_req_i, .motor_on_i, .step_req_i, .step_out_i,
    .id_req_i, .select_req_i, .side_one_i, .write_enable_i, .write_bit_i, .cpu_reset_i,
    .kbd_reset_i, .busy_o, .done_o, .drive_id_o, .drive_type_o, .track_zero_o,
    .write_protect_o, .index_o, .disk_changed_o, .ready_o, .read_bit_o, .motor_on_n_o,
    .drive1_select_n_o, .drive2_select_n_o, .drive3_select_n_o, .drive_reset_n_o,
    .head_side_n_o, .write_gate_n_o, .write_data_n_o, .head_step_n_o, .step_direction_o,
    .read_data_n_i, .disk_changed_n_i, .write_protect_n_i, .track_zero_n_i, .index_n_i,
    .ready_n_i);

  assign sel_n = {drive3_select_n_o, drive2_select_n_o, drive1_select_n_o};
  for (genvar g = 0; g < 3; g++) begin : gen_drv
    efd_drive_model #(.ID(IDS[g]), .PROT(g == 2), .DISK(g != 2)) efd_drive_model_inst (
      .clk_i, .reset_n_i(drive_reset_n_o), .sel_n_i(sel_n[g]), .motor_n_i(motor_on_n_o),
      .step_n_i(head_step_n_o), .dir_i(step_direction_o), .ready_n_o(rdy_n[g]),
      .track_zero_n_o(tz_n[g]), .write_protect_n_o(wp_n[g]), .index_n_o(ix_n[g]),
      .disk_changed_n_o(ch_n[g]), .read_data_n_o(rd_n[g]));
  end
  // Open-collector lines: any drive pulls low
  assign ready_n_i = &rdy_n;
  assign track_zero_n_i = &tz_n;
  assign write_protect_n_i = &wp_n;
  assign index_n_i = &ix_n;
  assign disk_changed_n_i = &ch_n;
  assign read_data_n_i = &rd_n;

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic run_op(input logic [1:0] drv, input int kind, input logic opt);
    int n;
    select_req_i = 1'b0;
    drive_i = drv;
    motor_on_i = opt;
    step_out_i = opt;
    motor_req_i = (kind == 0);
    step_req_i = (kind == 1);
    id_req_i = (kind == 2);
    cyc(1);
    {motor_req_i, step_req_i, id_req_i} = 3'b000;
    for (n = 0; n < 3000 && done_o !== 1'b1; n++) cyc(1);
    if (n == 3000) begin
      fail_count++;
      finish_test();
    end
    cyc(1);
  endtask : run_op

  // Held long enough that the next motor change keeps its hold time
  task automatic sel(input logic [1:0] drv);
    drive_i = drv;
    select_req_i = 1'b1;
    cyc(16);
  endtask : sel

  task automatic t_power();
    int n;
    for (n = 0; n < 100 && drive_reset_n_o !== 1'b1; n++) cyc(1);
    `CHK("power reset length", 1'b1, n >= 48 && n <= 52)
  endtask : t_power

  task automatic t_motor();
    int n;
    run_op(2'd1, 0, 1'b1);
    sel(2'd1);
    for (n = 0; n < 64 && index_o !== 1'b1; n++) cyc(1);
    `CHK("index_o", 1'b1, index_o)
    for (n = 0; n < 64 && read_bit_o !== 1'b1; n++) cyc(1);
    `CHK("read_bit_o", 1'b1, read_bit_o)
    `CHK("ready_o", 1'b1, ready_o)
    `CHK("track_zero_o", 1'b1, track_zero_o)
    `CHK("disk_changed_o", 1'b1, disk_changed_o)
    `CHK("write_protect_o", 1'b0, write_protect_o)
  endtask : t_motor

  task automatic t_step();
    run_op(2'd1, 1, 1'b0);
    sel(2'd1);
    `CHK("track_zero_o in", 1'b0, track_zero_o)
    `CHK("disk_changed_o", 1'b0, disk_changed_o)
    run_op(2'd1, 1, 1'b1);
    sel(2'd1);
    `CHK("track_zero_o out", 1'b1, track_zero_o)
    run_op(2'd3, 1, 1'b0);
    sel(2'd3);
    `CHK("disk_changed_o empty", 1'b1, disk_changed_o)
    `CHK("write_protect_o", 1'b1, write_protect_o)
  endtask : t_step

  task automatic t_pins();
    for (int v = 1; v >= 0; v--) begin
      side_one_i = v[0];
      write_enable_i = v[0];
      write_bit_i = v[0];
      cyc(2);
      `CHK("head_side_n_o", !v[0], head_side_n_o)
      `CHK("write_gate_n_o", !v[0], write_gate_n_o)
      `CHK("write_data_n_o", !v[0], write_data_n_o)
    end
  endtask : t_pins

  task automatic t_id();
    for (int d = 1; d <= 3; d++) begin
      run_op(d[1:0], 2, 1'b0);
      `CHK("drive_id_o", IDS[d-1], drive_id_o)
      `CHK("drive_type_o", TYPES[d-1], drive_type_o)
    end
  endtask : t_id

  task automatic t_resets();
    int n;
    cpu_reset_i = 1'b1;
    cyc(1);
    cpu_reset_i = 1'b0;
    cyc(2);
    for (n = 3; n < 400 && drive_reset_n_o !== 1'b1; n++) cyc(1);
    `CHK("command reset length", 1'b1, n >= 166 && n <= 174)
    sel(2'd1);
    kbd_reset_i = 1'b1;
    cyc(30);
    `CHK("drive_reset_n_o held", 1'b0, drive_reset_n_o)
    `CHK("write_protect_o in reset", 1'b1, write_protect_o)
    kbd_reset_i = 1'b0;
    cyc(200);
    `CHK("drive_reset_n_o released", 1'b1, drive_reset_n_o)
    `CHK("write_protect_o after", 1'b0, write_protect_o)
  endtask : t_resets

  initial begin
    {drive_i, motor_req_i, motor_on_i, step_req_i, step_out_i, id_req_i} = '0;
    {select_req_i, side_one_i, write_enable_i, write_bit_i, cpu_reset_i, kbd_reset_i} = '0;
    reset_n_i = 1'b0;
    cyc(8);
    `CHK("drive_reset_n_o", 1'b0, drive_reset_n_o)
    `CHK("selects idle", 3'b111, sel_n)
    reset_n_i = 1'b1;
    t_power();
    t_motor();
    t_step();
    t_pins();
    t_id();
    t_resets();
    finish_test();
  end
endmodule : efd_host_tb
`default_nettype wire

// File: verilog/efd_consts.svh
`ifndef EFD_CONSTS_SVH
`define EFD_CONSTS_SVH

// System clock rate in kHz (10 MHz)
`define EFD_CLK_KHZ          10000
// Motor setup/hold around select edge, in ns (least time, rounds up)
`define EFD_MOTOR_SETUP_NS   1400
`define EFD_MOTOR_SETUP_CYC  ((`EFD_MOTOR_SETUP_NS * `EFD_CLK_KHZ + 999999) / 1000000)
// Drive reset pulse on processor reset instruction, in ns
`define EFD_RESET_CMD_NS     17000
`define EFD_RESET_CMD_CYC    ((`EFD_RESET_CMD_NS * `EFD_CLK_KHZ) / 1000000)
// Power-up drive reset, in ms
`define EFD_RESET_PWR_MS     1000
`define EFD_RESET_PWR_CYC    (`EFD_RESET_PWR_MS * `EFD_CLK_KHZ)
// Identification sample count and default step timing
`define EFD_ID_BITS          16
`define EFD_STEP_WIDTH_CYC   10
`define EFD_STEP_GAP_CYC     30000
`define EFD_DRIVE_COUNT      3
// Identifier type codes; values are arbitrary
`define EFD_ID_STANDARD      16'h6a5c
`define EFD_ID_DOUBLE        16'h2d91
`define EFD_ID_USER_HI       8'h4b
`define EFD_ID_EXT_HI        8'hb4

`endif

// File: verilog/efd_host.sv
// Behaviour
// - Ready/ID shows disk spinning; not acted on
// - Head side low selects side one
// - Direction set before step; low steps in
// - Write data broadcast; gate low records
// - Select plus step clears change latch
// - Motor on: deselect, motor low, select
// - Motor off: deselect, motor high, select
// - Motor line steady 1.4 us around select
// - Drive reset: 1 s, 17 us, keyboard
// - Motor off: ready/ID returns ID bits
// - ID start: motor low, high, sample
// - Repeat sample steps, sixteen samples total
// - First sample is identifier MSB
// - Decode identifier against fixed table
// - One motor line, sequenced per select
`timescale 1ns/1ps
`default_nettype none
`include "efd_consts.svh"
module efd_host
  import efd_pkg::*;
#(
  parameter int STEP_WIDTH_CYC = `EFD_STEP_WIDTH_CYC,
  parameter int STEP_GAP_CYC   = `EFD_STEP_GAP_CYC,
  parameter int RESET_PWR_CYC  = `EFD_RESET_PWR_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // User side
  input  wire logic [1:0]  drive_i,
  input  wire logic        motor_req_i,
  input  wire logic        motor_on_i,
  input  wire logic        step_req_i,
  input  wire logic        step_out_i,
  input  wire logic        id_req_i,
  input  wire logic        select_req_i,
  input  wire logic        side_one_i,
  input  wire logic        write_enable_i,
  input  wire logic        write_bit_i,
  input  wire logic        cpu_reset_i,
  input  wire logic        kbd_reset_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [15:0]      drive_id_o,
  output efd_type_t        drive_type_o,
  output logic             track_zero_o,
  output logic             write_protect_o,
  output logic             index_o,
  output logic             disk_changed_o,
  output logic             ready_o,
  output logic             read_bit_o,
  // Cable side
  output logic             motor_on_n_o,
  output logic             drive1_select_n_o,
  output logic             drive2_select_n_o,
  output logic             drive3_select_n_o,
  output logic             drive_reset_n_o,
  output logic             head_side_n_o,
  output logic             write_gate_n_o,
  output logic             write_data_n_o,
  output logic             head_step_n_o,
  output logic             step_direction_o,
  input  wire logic        read_data_n_i,
  input  wire logic        disk_changed_n_i,
  input  wire logic        write_protect_n_i,
  input  wire logic        track_zero_n_i,
  input  wire logic        index_n_i,
  input  wire logic        ready_n_i
);
  localparam int HOLD_CYC = `EFD_MOTOR_SETUP_CYC;
  localparam int CMD_CYC  = `EFD_RESET_CMD_CYC;

  function automatic efd_type_t decode_id(input logic [15:0] id);
    if (id == `EFD_ID_STANDARD) decode_id = EFD_TYPE_STANDARD;
    else if (id == `EFD_ID_DOUBLE) decode_id = EFD_TYPE_DOUBLE_DENSITY;
    else if (id[15:8] == `EFD_ID_USER_HI) decode_id = EFD_TYPE_USER;
    else if (id[15:8] == `EFD_ID_EXT_HI) decode_id = EFD_TYPE_EXTENSION;
    else if (id == 16'h0000 || id == 16'haaaa || id == 16'h8000 || id == 16'h7fff
             || id[11:0] == 12'h000 || id[11:0] == 12'hfff
             || id == 16'h3333 || id == 16'hcccc) decode_id = EFD_TYPE_RESERVED;
    else decode_id = EFD_TYPE_UNKNOWN;
  endfunction : decode_id

  logic [5:0]  in_sync;
  efd_sync #(.WIDTH(6), .INIT(6'h3f)) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({read_data_n_i, disk_changed_n_i, write_protect_n_i,
                 track_zero_n_i, index_n_i, ready_n_i}),
    .sync_o    (in_sync)
  );

  efd_state_t  state;
  logic [1:0]  drive;
  logic        motor_level;
  logic        after_mset_id;
  logic        id_skip;
  logic [31:0] timer;
  logic [4:0]  id_count;
  logic [15:0] id_shift;
  logic [2:0]  select_n;
  logic        sel_active;
  logic [31:0] drst_count;
  logic        kbd_sync;

  // One select line asserted at most; index 0 means none
  always_comb begin
    select_n = 3'h7;
    if (sel_active && drive != 2'h0) begin
      select_n[drive - 2'h1] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state         <= EFD_IDLE;
      drive         <= 2'h0;
      motor_level   <= 1'b1;
      after_mset_id <= 1'b0;
      id_skip       <= 1'b0;
      timer         <= 32'h0;
      id_count      <= 5'h0;
      id_shift      <= 16'h0;
      sel_active    <= 1'b0;
      done_o        <= 1'b0;
      drive_id_o    <= 16'h0;
      drive_type_o  <= EFD_TYPE_UNKNOWN;
      head_step_n_o <= 1'b1;
      step_direction_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
      if (timer != 32'h0) begin
        timer <= timer - 32'h1;
      end
      case (state)
        EFD_IDLE: begin
          sel_active <= select_req_i && drive_i != 2'h0;
          drive      <= drive_i;
          if (drive_i != 2'h0 && (motor_req_i || id_req_i)) begin
            sel_active    <= 1'b0;
            after_mset_id <= id_req_i;
            motor_level   <= id_req_i ? 1'b0 : !motor_on_i;
            timer         <= 32'(HOLD_CYC);
            state         <= EFD_DESEL;
          end else if (step_req_i && drive_i != 2'h0) begin
            sel_active       <= 1'b1;
            step_direction_o <= step_out_i;
            timer            <= 32'(HOLD_CYC);
            state            <= EFD_STEP_LOW;
          end
        end
        EFD_DESEL: begin
          if (timer == 32'h0) begin
            sel_active <= 1'b1;
            timer      <= 32'(HOLD_CYC);
            state      <= EFD_SEL_HOLD;
          end
        end
        EFD_SEL_HOLD: begin
          if (timer == 32'h0) begin
            if (after_mset_id) begin
              sel_active    <= 1'b0;
              motor_level   <= 1'b1;
              after_mset_id <= 1'b0;
              id_skip       <= 1'b1;
              id_count      <= 5'h0;
              timer         <= 32'(HOLD_CYC);
              state         <= EFD_ID_DESEL;
            end else begin
              done_o <= 1'b1;
              state  <= EFD_IDLE;
            end
          end
        end
        EFD_STEP_LOW: begin
          if (timer == 32'h0 && head_step_n_o) begin
            head_step_n_o <= 1'b0;
            timer         <= 32'(STEP_WIDTH_CYC - 1);
          end else if (timer == 32'h0) begin
            head_step_n_o <= 1'b1;
            timer         <= 32'(STEP_GAP_CYC);
            state         <= EFD_STEP_GAP;
          end
        end
        EFD_STEP_GAP: begin
          if (timer == 32'h0) begin
            done_o <= 1'b1;
            state  <= EFD_IDLE;
          end
        end
        EFD_ID_DESEL: begin
          if (timer == 32'h0) begin
            sel_active <= 1'b1;
            timer      <= 32'(HOLD_CYC);
            state      <= EFD_ID_SEL;
          end
        end
        EFD_ID_SEL: begin
          if (timer == 32'h0 && id_skip) begin
            // Select pulse with motor high comes before the first sample
            sel_active <= 1'b0;
            id_skip    <= 1'b0;
            timer      <= 32'(HOLD_CYC);
            state      <= EFD_ID_DESEL;
          end else if (timer == 32'h0) begin
            state <= EFD_ID_SAMPLE;
          end
        end
        EFD_ID_SAMPLE: begin
          id_shift   <= {id_shift[14:0], in_sync[0]};
          id_count   <= id_count + 5'h1;
          sel_active <= 1'b0;
          timer      <= 32'(HOLD_CYC);
          if (id_count == 5'(`EFD_ID_BITS - 1)) begin
            drive_id_o   <= {id_shift[14:0], in_sync[0]};
            drive_type_o <= decode_id({id_shift[14:0], in_sync[0]});
            done_o       <= 1'b1;
            state        <= EFD_IDLE;
          end else begin
            state <= EFD_ID_DESEL;
          end
        end
        default: state <= EFD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      motor_on_n_o      <= 1'b1;
      drive1_select_n_o <= 1'b1;
      drive2_select_n_o <= 1'b1;
      drive3_select_n_o <= 1'b1;
      busy_o            <= 1'b0;
    end else begin
      motor_on_n_o      <= motor_level;
      drive1_select_n_o <= select_n[0];
      drive2_select_n_o <= select_n[1];
      drive3_select_n_o <= select_n[2];
      busy_o            <= state != EFD_IDLE;
    end
  end

  // Data path and side; registered to keep outputs glitch free
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      head_side_n_o  <= 1'b1;
      write_gate_n_o <= 1'b1;
      write_data_n_o <= 1'b1;
    end else begin
      head_side_n_o  <= !side_one_i;
      write_gate_n_o <= !write_enable_i;
      write_data_n_o <= !write_bit_i;
    end
  end

  // Status for the user, active high; ready is informational only
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      read_bit_o      <= 1'b0;
      disk_changed_o  <= 1'b0;
      write_protect_o <= 1'b0;
      track_zero_o    <= 1'b0;
      index_o         <= 1'b0;
      ready_o         <= 1'b0;
    end else begin
      read_bit_o      <= !in_sync[5];
      disk_changed_o  <= !in_sync[4];
      write_protect_o <= !in_sync[3];
      track_zero_o    <= !in_sync[2];
      index_o         <= !in_sync[1];
      ready_o         <= !in_sync[0];
    end
  end

  // Drive reset: power-up count, command count, keyboard level
  efd_sync #(.WIDTH(1), .INIT(1'b0)) u_kbd_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (kbd_reset_i),
    .sync_o    (kbd_sync)
  );

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      drst_count      <= 32'(RESET_PWR_CYC);
      drive_reset_n_o <= 1'b0;
    end else begin
      if (cpu_reset_i && drst_count < 32'(CMD_CYC)) begin
        drst_count <= 32'(CMD_CYC);
      end else if (drst_count != 32'h0) begin
        drst_count <= drst_count - 32'h1;
      end
      drive_reset_n_o <= !(drst_count != 32'h0 || kbd_sync);
    end
  end
endmodule : efd_host
`default_nettype wire

// File: verilog/efd_pkg.sv
package efd_pkg;
  typedef enum logic [3:0] {
    EFD_IDLE,
    EFD_DESEL,
    EFD_MSET,
    EFD_SEL,
    EFD_SEL_HOLD,
    EFD_STEP_LOW,
    EFD_STEP_GAP,
    EFD_ID_DESEL,
    EFD_ID_SEL,
    EFD_ID_SAMPLE
  } efd_state_t;

  // Drive type decoded from the identifier
  typedef enum logic [2:0] {
    EFD_TYPE_STANDARD,
    EFD_TYPE_DOUBLE_DENSITY,
    EFD_TYPE_USER,
    EFD_TYPE_EXTENSION,
    EFD_TYPE_RESERVED,
    EFD_TYPE_UNKNOWN
  } efd_type_t;
endpackage : efd_pkg

// File: verilog/efd_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; output moves once stages two and three agree.
module efd_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync_o <= INIT;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_o[i] <= stage3[i];
        end
      end
    end
  end
endmodule : efd_sync
`default_nettype wire
